// >>> rtl/crt_pkg.sv
package crt_pkg;
  // byte addresses of the register words
  localparam logic [7:0] CTRL_OFFS    = 8'hc8;
  localparam logic [7:0] CNT_LO_OFFS  = 8'hcc;
  localparam logic [7:0] CNT_HI_OFFS  = 8'hd0;
  localparam logic [7:0] CAP_LO_OFFS  = 8'hd4;
  localparam logic [7:0] CAP_HI_OFFS  = 8'hd8;
  localparam logic [7:0] PWR_OFFS     = 8'hdc;
  localparam logic [7:0] IEN_OFFS     = 8'he0;
  // control field positions
  localparam int OVF_BIT   = 7;
  localparam int EXT_BIT   = 6;
  localparam int RXSEL_BIT = 5;
  localparam int TXSEL_BIT = 4;
  localparam int EXEN_BIT  = 3;
  localparam int RUN_BIT   = 2;
  localparam int CT_BIT    = 1;
  localparam int CPRL_BIT  = 0;
  // second port baud selects in the power control word
  localparam int RX1_BIT   = 1;
  localparam int TX1_BIT   = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PWR_RST  = 8'h00;
  // prescale divisors
  localparam int TIMER_DIV = 12;
  localparam int BAUD_DIV  = 2;
  localparam int UART_DIV  = 16;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic ovf;
    logic ext;
    logic rx_sel;
    logic tx_sel;
    logic exen;
    logic run;
    logic ct;
    logic cprl;
  } crt_ctrl_t;

  typedef struct packed {
    logic rx0;
    logic tx0;
    logic rx1;
    logic tx1;
  } crt_baud_t;
endpackage : crt_pkg

// >>> rtl/crt_fall_det.sv
`timescale 1ns/1ps
// falling-edge detector on a synchronous input; fall is combinational from din and the registered last sample
module crt_fall_det (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      fall
);
  logic prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= din;
    end
  end

  assign fall = prev_q & ~din;
endmodule : crt_fall_det

// >>> rtl/crt_prescale.sv
`timescale 1ns/1ps
// free-running divider, one-cycle tick every div cycles
module crt_prescale #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt_q;

  assign tick = (cnt_q == div - W'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end
endmodule : crt_prescale

// >>> rtl/crt_timer.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module crt_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        count_input_pin,
  input  wire logic        trigger_pin,
  input  wire logic        timer1_overflow,
  output logic             irq,
  output crt_pkg::crt_baud_t baud_clk
);
  crt_pkg::crt_ctrl_t ctrl_q;
  logic [15:0]        cnt_q;
  logic [15:0]        cap_q;
  logic [1:0]         pwr_q;
  logic               ien_q;
  logic               irq_q;
  crt_pkg::crt_baud_t baud_q;

  // ---------------- prescalers and pin edges
  logic       tick12;
  logic       tick2;
  logic       cnt_fall;
  logic       trg_fall;

  crt_prescale #(.W(4)) u_div12 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (4'(crt_pkg::TIMER_DIV)),
    .tick    (tick12)
  );

  crt_prescale #(.W(4)) u_div2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (4'(crt_pkg::BAUD_DIV)),
    .tick    (tick2)
  );

  crt_fall_det u_cnt_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (count_input_pin),
    .fall    (cnt_fall)
  );

  crt_fall_det u_trg_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (trigger_pin),
    .fall    (trg_fall)
  );

  // ---------------- mode decode
  wire baud_mode = ctrl_q.rx_sel | ctrl_q.tx_sel | pwr_q[crt_pkg::RX1_BIT]
                   | pwr_q[crt_pkg::TX1_BIT];
  wire capture_mode = ctrl_q.cprl & ~baud_mode;
  wire int_tick = baud_mode ? tick2 : tick12;
  wire adv = ctrl_q.run & (ctrl_q.ct ? cnt_fall : int_tick);
  wire roll = adv & (cnt_q == 16'hffff);
  wire trg_evt = ctrl_q.exen & trg_fall;
  wire trg_reload = trg_evt & ~capture_mode & ~baud_mode;
  wire trg_capture = trg_evt & capture_mode;
  wire reload = (roll & ~capture_mode) | trg_reload;
  wire ovf_set = roll & ~baud_mode;
  wire ext_set = trg_evt;

  // ---------------- AXI4-Lite write path
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;

  wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  // next-cycle state, so that the ready outputs come from flops
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire aw_have_d = aw_take | (aw_have_q & ~do_write);
  wire w_have_d  = w_take | (w_have_q & ~do_write);
  wire bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire wr_ctrl  = do_write & (awaddr_q == crt_pkg::CTRL_OFFS) & wstrb_q[0];
  wire wr_cntl  = do_write & (awaddr_q == crt_pkg::CNT_LO_OFFS) & wstrb_q[0];
  wire wr_cnth  = do_write & (awaddr_q == crt_pkg::CNT_HI_OFFS) & wstrb_q[0];
  wire wr_capl  = do_write & (awaddr_q == crt_pkg::CAP_LO_OFFS) & wstrb_q[0];
  wire wr_caph  = do_write & (awaddr_q == crt_pkg::CAP_HI_OFFS) & wstrb_q[0];
  wire wr_pwr   = do_write & (awaddr_q == crt_pkg::PWR_OFFS) & wstrb_q[0];
  wire wr_ien   = do_write & (awaddr_q == crt_pkg::IEN_OFFS) & wstrb_q[0];
  wire wr_hit   = (awaddr_q == crt_pkg::CTRL_OFFS) | (awaddr_q == crt_pkg::CNT_LO_OFFS)
                | (awaddr_q == crt_pkg::CNT_HI_OFFS) | (awaddr_q == crt_pkg::CAP_LO_OFFS)
                | (awaddr_q == crt_pkg::CAP_HI_OFFS) | (awaddr_q == crt_pkg::PWR_OFFS)
                | (awaddr_q == crt_pkg::IEN_OFFS);
  wire [7:0] wbyte = wdata_q[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_d & ~bvalid_d;
      s_axi_wready  <= ~w_have_d & ~bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= crt_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? crt_pkg::RESP_OKAY : crt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- control and flags; hardware set wins over write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= crt_pkg::crt_ctrl_t'(crt_pkg::CTRL_RST);
      pwr_q  <= crt_pkg::PWR_RST[1:0];
      ien_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= crt_pkg::crt_ctrl_t'(wbyte);
      end
      if (ovf_set) begin
        ctrl_q.ovf <= 1'b1;
      end
      if (ext_set) begin
        ctrl_q.ext <= 1'b1;
      end
      if (wr_pwr) begin
        pwr_q <= wbyte[1:0];
      end
      if (wr_ien) begin
        ien_q <= wbyte[0];
      end
    end
  end

  // ---------------- count and capture/reload registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else if (reload) begin
      cnt_q <= cap_q;
    end else if (adv) begin
      cnt_q <= cnt_q + 16'h0001;
    end else if (wr_cntl) begin
      cnt_q[7:0] <= wbyte;
    end else if (wr_cnth) begin
      cnt_q[15:8] <= wbyte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q <= 16'h0000;
    end else if (trg_capture) begin
      cap_q <= cnt_q;
    end else if (wr_capl) begin
      cap_q[7:0] <= wbyte;
    end else if (wr_caph) begin
      cap_q[15:8] <= wbyte;
    end
  end

  // ---------------- interrupt and baud clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q  <= 1'b0;
      baud_q <= '0;
    end else begin
      irq_q      <= ien_q & (ctrl_q.ovf | ctrl_q.ext);
      baud_q.rx0 <= ctrl_q.rx_sel ? roll : timer1_overflow;
      baud_q.tx0 <= ctrl_q.tx_sel ? roll : timer1_overflow;
      baud_q.rx1 <= pwr_q[crt_pkg::RX1_BIT] ? roll : timer1_overflow;
      baud_q.tx1 <= pwr_q[crt_pkg::TX1_BIT] ? roll : timer1_overflow;
    end
  end
  assign irq      = irq_q;
  assign baud_clk = baud_q;

  // ---------------- AXI4-Lite read path
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case ({s_axi_araddr[7:2], 2'b00})
      crt_pkg::CTRL_OFFS:   rd_byte = ctrl_q;
      crt_pkg::CNT_LO_OFFS: rd_byte = cnt_q[7:0];
      crt_pkg::CNT_HI_OFFS: rd_byte = cnt_q[15:8];
      crt_pkg::CAP_LO_OFFS: rd_byte = cap_q[7:0];
      crt_pkg::CAP_HI_OFFS: rd_byte = cap_q[15:8];
      crt_pkg::PWR_OFFS:    rd_byte = {6'b00_0000, pwr_q};
      crt_pkg::IEN_OFFS:    rd_byte = {7'b000_0000, ien_q};
      default:              rd_hit  = 1'b0;
    endcase
  end

  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= crt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? crt_pkg::RESP_OKAY : crt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- assertions
  property p_hold_stopped;
    @(posedge aclk) disable iff (!aresetn)
      (!ctrl_q.run && !reload && !wr_cntl && !wr_cnth) |=> $stable(cnt_q);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("count moved while stopped");

  property p_no_trigger;
    @(posedge aclk) disable iff (!aresetn)
      (!ctrl_q.exen && !wr_capl && !wr_caph) |=> $stable(cap_q);
  endproperty
  a_no_trigger: assert property (p_no_trigger) else $error("capture without enable");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
      trg_capture |=> cap_q == $past(cnt_q) && ctrl_q.ext;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      (roll && !capture_mode) |=> cnt_q == $past(cap_q);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_ovf_flag;
    @(posedge aclk) disable iff (!aresetn)
      (roll && !baud_mode) |=> ctrl_q.ovf;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_baud_no_flag;
    @(posedge aclk) disable iff (!aresetn)
      (baud_mode && !ctrl_q.ovf && !wr_ctrl) |=> !ctrl_q.ovf;
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud mode");

  property p_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q.ext && !wr_ctrl) |=> ctrl_q.ext;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      (ien_q && (ctrl_q.ovf || ctrl_q.ext)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_baud_route;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q.tx_sel && roll) |=> baud_clk.tx0;
  endproperty
  a_baud_route: assert property (p_baud_route) else $error("tx baud pulse missing");

  property p_trg_reload;
    @(posedge aclk) disable iff (!aresetn)
      (trg_evt && !capture_mode && !baud_mode) |=> cnt_q == $past(cap_q) && ctrl_q.ext;
  endproperty
  a_trg_reload: assert property (p_trg_reload) else $error("trigger reload missed");

  property p_ext_flag;
    @(posedge aclk) disable iff (!aresetn)
      trg_evt |=> ctrl_q.ext;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("event flag not set");

  property p_ovf_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q.ovf && !wr_ctrl) |=> ctrl_q.ovf;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared");
endmodule : crt_timer

// >>> verif/crt_pin_model.sv
`timescale 1ns/1ps
// far side: count pin, trigger pin and the other timer's overflow
module crt_pin_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cnt_en,
  input  wire logic trig_req,
  output logic      count_input_pin,
  output logic      trigger_pin,
  output logic      timer1_overflow
);
  logic [3:0] ph_q;
  logic [2:0] trg_q;
  logic [4:0] t1_q;

  // pin stands high outside bursts
  always_ff @(posedge aclk) begin
    if (!aresetn || !cnt_en) begin
      ph_q            <= 4'h0;
      count_input_pin <= 1'b1;
    end else if (ph_q == 4'hb) begin
      ph_q            <= 4'h0;
      count_input_pin <= ~count_input_pin;
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_q <= 3'h0;
    end else if (trig_req) begin
      trg_q <= 3'h4;
    end else if (trg_q != 3'h0) begin
      trg_q <= trg_q - 3'h1;
    end
  end
  assign trigger_pin = (trg_q == 3'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn || t1_q == 5'h13) begin
      t1_q <= 5'h00;
    end else begin
      t1_q <= t1_q + 5'h01;
    end
  end
  assign timer1_overflow = (t1_q == 5'h13);
endmodule : crt_pin_model

// >>> verif/tb_crt_timer.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_crt_timer;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cnt_en = 1'b0;
  logic trig_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic cpin, tpin, t1ovf;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  crt_pkg::crt_baud_t baud_clk;
  int n_fail = 0;
  int n_tests = 0;
  int c [5];

  always #20 aclk = ~aclk;

  crt_timer crt_timer_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_input_pin(cpin), .trigger_pin(tpin),
    .timer1_overflow(t1ovf), .irq(irq), .baud_clk(baud_clk));

  crt_pin_model crt_pin_model_inst (.aclk(aclk), .aresetn(aresetn), .cnt_en(cnt_en),
    .trig_req(trig_req), .count_input_pin(cpin), .trigger_pin(tpin),
    .timer1_overflow(t1ovf));

  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic timeout;
    n_fail++;
    close_out();
  endtask : timeout

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 64) timeout();
    `CHK(bresp, er)
  endtask : wr

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, crt_pkg::RESP_OKAY);
  endtask : w

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 64) timeout();
    d = rdata[7:0];
    r = rresp;
    `CHK(rdata[31:8], 24'h00_0000)
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, crt_pkg::RESP_OKAY)
  endtask : chk

  task automatic trig;
    @(posedge aclk);
    trig_req <= 1'b1;
    @(posedge aclk);
    trig_req <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask : trig

  // counts rx0, tx0, rx1, tx1 and other-timer pulses over n cycles
  task automatic pulses(input int n);
    logic [4:0] v;
    c = '{default: 0};
    repeat (n) begin
      @(posedge aclk);
      v = {baud_clk, t1ovf};
      for (int j = 0; j < 5; j++) c[4-j] += int'(v[4-j] === 1'b1);
    end
  endtask : pulses

  function automatic logic near(input int a, input int b);
    return (a >= b - 1) && (a <= b + 1);
  endfunction : near

  initial begin
    logic [7:0] d0;
    logic [1:0] r;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(crt_pkg::CTRL_OFFS, crt_pkg::CTRL_RST);
    chk(crt_pkg::PWR_OFFS, crt_pkg::PWR_RST);
    rd(8'he4, d0, r);
    `CHK(r, crt_pkg::RESP_SLVERR)
    wr(8'he4, 8'h00, crt_pkg::RESP_SLVERR);
    // internal timer, 240 cycles
    w(crt_pkg::CNT_LO_OFFS, 8'h00);
    w(crt_pkg::CNT_HI_OFFS, 8'h00);
    w(crt_pkg::CTRL_OFFS, 8'h04);
    repeat (240) @(posedge aclk);
    w(crt_pkg::CTRL_OFFS, 8'h00);
    rd(crt_pkg::CNT_LO_OFFS, d0, r);
    `CHK(near(int'(d0), 20), 1'b1)
    repeat (100) @(posedge aclk);
    chk(crt_pkg::CNT_LO_OFFS, d0);
    // capture mode roll-over and interrupt
    w(crt_pkg::IEN_OFFS, 8'h01);
    w(crt_pkg::CNT_LO_OFFS, 8'hfe);
    w(crt_pkg::CNT_HI_OFFS, 8'hff);
    w(crt_pkg::CTRL_OFFS, 8'h05);
    repeat (48) @(posedge aclk);
    chk(crt_pkg::CTRL_OFFS, 8'h85);
    `CHK(irq, 1'b1)
    w(crt_pkg::IEN_OFFS, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    w(crt_pkg::IEN_OFFS, 8'h01);
    repeat (200) @(posedge aclk);
    chk(crt_pkg::CTRL_OFFS, 8'h85);
    w(crt_pkg::CTRL_OFFS, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    // trigger ignored, then capture
    w(crt_pkg::CAP_LO_OFFS, 8'h55);
    w(crt_pkg::CAP_HI_OFFS, 8'h66);
    w(crt_pkg::CNT_LO_OFFS, 8'h34);
    w(crt_pkg::CNT_HI_OFFS, 8'h12);
    w(crt_pkg::CTRL_OFFS, 8'h07);
    trig();
    chk(crt_pkg::CAP_LO_OFFS, 8'h55);
    chk(crt_pkg::CTRL_OFFS, 8'h07);
    w(crt_pkg::CTRL_OFFS, 8'h0f);
    trig();
    chk(crt_pkg::CAP_LO_OFFS, 8'h34);
    chk(crt_pkg::CAP_HI_OFFS, 8'h12);
    chk(crt_pkg::CTRL_OFFS, 8'h4f);
    // auto-reload by trigger, then by roll-over in counter mode
    w(crt_pkg::CAP_LO_OFFS, 8'hab);
    w(crt_pkg::CAP_HI_OFFS, 8'hcd);
    w(crt_pkg::CTRL_OFFS, 8'h0e);
    trig();
    chk(crt_pkg::CNT_LO_OFFS, 8'hab);
    chk(crt_pkg::CNT_HI_OFFS, 8'hcd);
    chk(crt_pkg::CTRL_OFFS, 8'h4e);
    w(crt_pkg::CNT_LO_OFFS, 8'hff);
    w(crt_pkg::CNT_HI_OFFS, 8'hff);
    w(crt_pkg::CTRL_OFFS, 8'h06);
    cnt_en <= 1'b1;
    repeat (40) @(posedge aclk);
    cnt_en <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(crt_pkg::CNT_LO_OFFS, 8'hac);
    chk(crt_pkg::CNT_HI_OFFS, 8'hcd);
    chk(crt_pkg::CTRL_OFFS, 8'h86);
    // baud generation, reload of ffff overflows every tick
    w(crt_pkg::CAP_LO_OFFS, 8'hff);
    w(crt_pkg::CAP_HI_OFFS, 8'hff);
    w(crt_pkg::CNT_LO_OFFS, 8'hff);
    w(crt_pkg::CNT_HI_OFFS, 8'hff);
    w(crt_pkg::CTRL_OFFS, 8'h3c);
    repeat (8) @(posedge aclk);
    pulses(100);
    `CHK(near(c[4], 50), 1'b1)
    `CHK(c[3], c[4])
    `CHK(near(c[2], c[0]), 1'b1)
    trig();
    chk(crt_pkg::CTRL_OFFS, 8'h7c);
    w(crt_pkg::PWR_OFFS, 8'h03);
    pulses(100);
    `CHK(near(c[2], 50), 1'b1)
    `CHK(c[1], c[2])
    w(crt_pkg::CTRL_OFFS, 8'h00);
    w(crt_pkg::PWR_OFFS, 8'h00);
    pulses(100);
    `CHK(near(c[4], c[0]), 1'b1)
    `CHK(near(c[3], c[0]), 1'b1)
    close_out();
  end
endmodule : tb_crt_timer
